//--- rtl/card_pwr_pkg.sv
// Package with constants and types for the card power and presence controller.
package card_pwr_pkg;

    // Card supply level select values.
    localparam logic LEVEL_1V875 = 1'b0;  // Low card supply level.
    localparam logic LEVEL_3V0   = 1'b1;  // High card supply level.

    // Position of the level-select bit in the outside regulator's control word.
    localparam int unsigned AUX_REG_LOCATION  = 7;
    localparam int unsigned LEVEL_SEL_BIT_POS = 18;

    // Card clock divider: card clock is the system clock divided by twice this count plus two.
    localparam logic [3:0] CARD_CLK_DIV_LAST = 4'h3;

    // Power-down sequencer states.
    typedef enum logic [2:0] {
        PD_IDLE  = 3'b000,
        PD_RST   = 3'b001,
        PD_CLK   = 3'b010,
        PD_IO    = 3'b011,
        PD_VCC   = 3'b100,
        PD_OFF   = 3'b101
    } pd_state_t;

endpackage

//--- rtl/card_pd_if.sv
// Interface carrying the power-down request and its progress between modules.
`timescale 1ns/1ps
`default_nettype none
interface card_pd_if;
    logic      start;      // One-cycle request to run the power-down sequence.
    logic      rst_low;    // Card reset must be driven low.
    logic      clk_stop;   // Card clock must be held low.
    logic      io_low;     // Card data line must be driven low.
    logic      vcc_off;    // Card supply must be removed.
    logic      busy;       // Sequence is in progress.

    modport seq  (input start, output rst_low, clk_stop, io_low, vcc_off, busy);
    modport ctrl (output start, input rst_low, clk_stop, io_low, vcc_off, busy);
endinterface
`default_nettype wire

//--- rtl/card_pd_seq.sv
// Four-step card power-down sequencer, one card-line change per clock.
`timescale 1ns/1ps
`default_nettype none
module card_pd_seq
    import card_pwr_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst_n_sync,
    // Request and step outputs.
    card_pd_if.seq    pd
);

    pd_state_t state_reg;   // Current step of the sequence.
    pd_state_t state_next;  // Step for the next cycle.

    // ----------------------------------------------------------------
    // Step decode
    // ----------------------------------------------------------------
    // Each state from PD_RST to PD_VCC advances exactly one step, so the four line changes
    // always land on distinct cycles.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PD_IDLE: begin
                if (pd.start) begin
                    state_next = PD_RST;
                end
            end
            PD_RST:  state_next = PD_CLK;  // Reset low first.
            PD_CLK:  state_next = PD_IO;   // Then clock stopped low.
            PD_IO:   state_next = PD_VCC;  // Then data line low.
            PD_VCC:  state_next = PD_OFF;  // Supply removed last.
            PD_OFF: begin
                // Stay powered down until reset or a new start, which runs the sequence again.
                if (pd.start) begin
                    state_next = PD_RST;
                end
            end
            default: state_next = PD_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_reg <= PD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Step flags are sticky until a new start in PD_OFF returns to PD_RST, where only rst_low stays set.
    assign pd.rst_low  = (state_reg != PD_IDLE);
    assign pd.clk_stop = (state_reg == PD_CLK) || (state_reg == PD_IO)
                      || (state_reg == PD_VCC) || (state_reg == PD_OFF);
    assign pd.io_low   = (state_reg == PD_IO) || (state_reg == PD_VCC)
                      || (state_reg == PD_OFF);
    assign pd.vcc_off  = (state_reg == PD_VCC) || (state_reg == PD_OFF);
    assign pd.busy     = (state_reg != PD_IDLE) && (state_reg != PD_OFF);

endmodule
`default_nettype wire

//--- rtl/sim_card_power_presence_ctrl.sv
// Top level of the card power and presence-detect controller.
//
// Overview of operation
// - Block drives the regulator enable pin.
// - Detect insertion and removal, maskable interrupt.
// - Falling presence input means card removed.
// - Power-down: reset, clock, data, then supply.
// - Auto power-down on presence event when enabled.
// - Forced power-down ignores enable and events.
// - Own clock generator, never an interrupt source.
// - Data line only driven low, no transmit path; its level is read back.
`timescale 1ns/1ps
`default_nettype none
module sim_card_power_presence_ctrl
    import card_pwr_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Software control bits.
    input  wire logic supply_level_select,    // Requested card supply level.
    input  wire logic card_power_on,          // Software drive of the supply pin.
    input  wire logic card_rst_release,       // Software drive of card reset.
    input  wire logic card_clk_run,           // Software enable of the card clock.
    input  wire logic auto_pd_enable,         // Allow power-down on presence event.
    input  wire logic force_pd,               // Level; rising edge forces power-down.
    input  wire logic presence_irq_mask,      // High blocks the presence interrupt.
    input  wire logic presence_irq_clear,     // One-cycle clear of the event flags.
    // Card side pins.
    input  wire logic card_presence_detect,   // High while a card is seated.
    input  wire logic card_io_in,             // Data line level read back.
    output var  logic card_supply_enable_out, // Drives the regulator enable pin.
    output var  logic card_level_out,         // Level-select bit toward regulator.
    output var  logic card_rst_out,           // Card reset, low is reset.
    output var  logic card_clk_out,           // Card clock.
    output var  logic card_io_out,            // Data line drive value.
    output var  logic card_io_oe,             // High while data line is driven.
    // Status.
    output var  logic card_present,           // Synchronised presence level.
    output var  logic insert_flag,            // Sticky insertion event.
    output var  logic remove_flag,            // Sticky removal event.
    output var  logic presence_irq,           // Masked presence interrupt.
    output var  logic pd_busy,                // Power-down running.
    output var  logic card_io_sample          // Synchronised data line level.
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;  // Two-stage reset release chain.
    logic       rst_n_sync;    // Released reset used everywhere else.

    // Reset asserts at once and releases after two clean edges.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync_reg[1];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic pd_meta_reg;   // First stage, read only by the second.
    logic pd_sync_reg;   // Stable presence level.
    logic pd_prev_reg;   // Previous stable level for edge detection.
    logic io_meta_reg;   // First stage of the data line.
    logic io_sync_reg;   // Stable data line level.

    // Pin inputs pass two flops; the idle level is high (card seated).
    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pd_meta_reg <= 1'b1;
            pd_sync_reg <= 1'b1;
            pd_prev_reg <= 1'b1;
            io_meta_reg <= 1'b1;
            io_sync_reg <= 1'b1;
        end else begin
            pd_meta_reg <= card_presence_detect;
            pd_sync_reg <= pd_meta_reg;
            pd_prev_reg <= pd_sync_reg;
            io_meta_reg <= card_io_in;
            io_sync_reg <= io_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Presence events
    // ----------------------------------------------------------------
    wire remove_evt = pd_prev_reg & ~pd_sync_reg;   // High-to-low is removal.
    wire insert_evt = ~pd_prev_reg & pd_sync_reg;   // Low-to-high is insertion.
    wire any_evt    = remove_evt | insert_evt;

    logic insert_flag_reg;   // Sticky insertion flag.
    logic remove_flag_reg;   // Sticky removal flag.
    logic irq_reg;           // Registered interrupt output.

    // A new event in the clear cycle wins, so no event is lost.
    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            insert_flag_reg <= 1'b0;
            remove_flag_reg <= 1'b0;
            irq_reg         <= 1'b0;
        end else begin
            insert_flag_reg <= insert_evt | (insert_flag_reg & ~presence_irq_clear);
            remove_flag_reg <= remove_evt | (remove_flag_reg & ~presence_irq_clear);
            // Only presence events feed the interrupt; the clock divider never does.
            irq_reg <= ~presence_irq_mask & (insert_evt | remove_evt
                     | ((insert_flag_reg | remove_flag_reg) & ~presence_irq_clear));
        end
    end

    // ----------------------------------------------------------------
    // Power-down triggering
    // ----------------------------------------------------------------
    logic force_prev_reg;  // Previous force level for edge detection.
    card_pd_if pd_bus ();

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            force_prev_reg <= 1'b0;
        end else begin
            force_prev_reg <= force_pd;
        end
    end

    wire force_evt = force_pd & ~force_prev_reg;     // Forced, independent of enable.
    wire auto_evt  = any_evt & auto_pd_enable;       // Auto only when enabled.
    assign pd_bus.start = (force_evt | auto_evt) & ~pd_bus.busy;

    // Shared step sequencer.
    card_pd_seq u_pd_seq (
        .clk_sys    (clk_sys),
        .rst_n_sync (rst_n_sync),
        .pd         (pd_bus)
    );

    // ----------------------------------------------------------------
    // Card clock generator
    // ----------------------------------------------------------------
    logic [3:0] div_reg;   // Divider count for the card clock.
    logic       cclk_reg;  // Free-running divided clock level.

    // Dedicated generator for the card clock, as a toggle on an enable.
    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            div_reg  <= 4'h0;
            cclk_reg <= 1'b0;
        end else if (div_reg == CARD_CLK_DIV_LAST) begin
            div_reg  <= 4'h0;
            cclk_reg <= ~cclk_reg;
        end else begin
            div_reg  <= div_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Card line outputs
    // ----------------------------------------------------------------
    // Software owns power-up; hardware only forces lines down.
    wire sw_mode     = ~pd_bus.rst_low;
    wire rst_next    = sw_mode & card_rst_release;
    wire clk_next    = ~pd_bus.clk_stop & card_clk_run & cclk_reg;
    wire io_oe_next  = pd_bus.io_low;
    wire vcc_next    = ~pd_bus.vcc_off & card_power_on;

    // All top outputs come from flops; reset leaves the card unpowered.
    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            card_supply_enable_out <= 1'b0;
            card_level_out         <= LEVEL_1V875;
            card_rst_out           <= 1'b0;
            card_clk_out           <= 1'b0;
            card_io_out            <= 1'b0;
            card_io_oe             <= 1'b0;
            pd_busy                <= 1'b0;
            card_io_sample         <= 1'b1;
            card_present           <= 1'b1;
        end else begin
            card_supply_enable_out <= vcc_next;              // Gates the regulator.
            card_level_out         <= supply_level_select;   // Two levels only.
            card_rst_out           <= rst_next;
            card_clk_out           <= clk_next;
            card_io_out            <= 1'b0;
            card_io_oe             <= io_oe_next;
            pd_busy                <= pd_bus.busy;
            card_io_sample         <= io_sync_reg;           // Feeds the receive path.
            card_present           <= pd_sync_reg;
        end
    end

    assign insert_flag  = insert_flag_reg;
    assign remove_flag  = remove_flag_reg;
    assign presence_irq = irq_reg;

endmodule
`default_nettype wire

//--- verification/card_pwr_checker.sv
// Concurrent checks on the card power controller's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module card_pwr_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Software controls.
    input wire logic card_power_on,
    input wire logic card_clk_run,
    input wire logic auto_pd_enable,
    input wire logic force_pd,
    input wire logic presence_irq_mask,
    input wire logic presence_irq_clear,
    // Card pins and status.
    input wire logic card_supply_enable_out,
    input wire logic card_rst_out,
    input wire logic card_clk_out,
    input wire logic card_io_out,
    input wire logic card_io_oe,
    input wire logic card_present,
    input wire logic insert_flag,
    input wire logic remove_flag,
    input wire logic presence_irq,
    input wire logic pd_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Power-down sequence and card lines
    // ------------------------------------------------------------
    pd_order_a: assert property (
        $rose(pd_busy) |-> !card_rst_out ##1 !card_clk_out ##1 card_io_oe
            ##1 !card_supply_enable_out ##1 !pd_busy) else $error("power-down order broken");
    io_rise_a: assert property (
        $rose(card_io_oe) |-> pd_busy && !$past(card_clk_out)) else $error("data line step early");
    force_start_a: assert property (
        $rose(force_pd) && !pd_busy && !card_io_oe |-> ##[1:3] (pd_busy && !card_rst_out))
        else $error("forced power-down not started");
    auto_gate_a: assert property (
        $rose(pd_busy) |-> $past(auto_pd_enable, 2) || $past(force_pd, 2))
        else $error("power-down unasked");
    io_low_a: assert property (card_io_oe |-> !card_io_out) else $error("data line not low");
    supply_follow_a: assert property (
        $rose(card_power_on) && !pd_busy && !card_io_oe |-> ##[1:2] card_supply_enable_out)
        else $error("supply pin ignores software");
    clk_idle_a: assert property (!card_clk_run [*8] |-> !card_clk_out) else $error("clock runs");
    // ------------------------------------------------------------
    // Presence events and interrupt
    // ------------------------------------------------------------
    remove_flag_a: assert property ($fell(card_present) |-> ##[0:2] remove_flag)
        else $error("removal not flagged");
    insert_flag_a: assert property ($rose(card_present) |-> ##[0:2] insert_flag)
        else $error("insertion not flagged");
    irq_mask_a: assert property (
        presence_irq_mask && $past(presence_irq_mask) |-> !presence_irq) else $error("mask leaks");
    irq_raise_a: assert property (
        (insert_flag || remove_flag) && !presence_irq_mask && !$past(presence_irq_mask)
            && !presence_irq_clear |-> ##[0:2] presence_irq) else $error("interrupt missing");
    // Main scenarios seen at least once.
    cover property ($rose(pd_busy));
    cover property ($rose(remove_flag));
    cover property ($rose(presence_irq));
endmodule
bind sim_card_power_presence_ctrl card_pwr_checker u_card_pwr_checker (
    .clk_sys, .rstn, .card_power_on, .card_clk_run, .auto_pd_enable, .force_pd,
    .presence_irq_mask, .presence_irq_clear, .card_supply_enable_out, .card_rst_out,
    .card_clk_out, .card_io_out, .card_io_oe, .card_present, .insert_flag, .remove_flag,
    .presence_irq, .pd_busy
);
`default_nettype wire

//--- verification/card_partner.sv
// Behavioural card holder and outside card supply regulator.
`timescale 1ns/1ps
`default_nettype none
module card_partner (
    // Controls from the bench.
    input  wire logic regulator_bus_enable,   // Serial-bus enable bit of the regulator.
    input  wire logic card_seated,            // High while a card sits in the holder.
    // Pins from the controller.
    input  wire logic card_supply_enable_out, // Regulator enable pin.
    input  wire logic card_level_out,         // Level-select bit.
    input  wire logic card_io_out,            // Data line drive value.
    input  wire logic card_io_oe,             // Data line drive enable.
    // Responses.
    output var  logic vcc_on,                 // Card supply present.
    output var  logic vcc_3v0,                // High for the upper level, else 1.875 V.
    output var  logic card_presence_detect,   // Presence pin.
    output var  logic card_io_in              // Data line level.
);
    // Supply is on only while both enables are high; no third level exists.
    assign vcc_on = regulator_bus_enable & card_supply_enable_out;
    // One bit picks the level, so a stray value cannot select an unsupported supply.
    assign vcc_3v0 = card_level_out;
    // Pull-up holds the pin high while seated; removal pulls it low.
    assign card_presence_detect = card_seated;
    // The data line has a pull-up, so a released line reads high.
    assign card_io_in = card_io_oe ? card_io_out : 1'b1;
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the card power and presence controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import card_pwr_pkg::*;
    // Bench-driven controls, pins and status.
    logic clk_sys, rstn, supply_level_select, card_power_on, card_rst_release, card_clk_run;
    logic auto_pd_enable, force_pd, presence_irq_mask, presence_irq_clear, card_seated;
    logic regulator_bus_enable, vcc_on, vcc_3v0, card_presence_detect, card_io_in;
    logic card_supply_enable_out, card_level_out, card_rst_out, card_clk_out, card_io_out;
    logic card_io_oe, card_present, insert_flag, remove_flag, presence_irq, pd_busy;
    logic card_io_sample, prev_clk;
    int   error_cnt, checks, rises;
    sim_card_power_presence_ctrl u_sim_card_power_presence_ctrl (.*);
    card_partner u_card_partner (.*);
    // Free-running 25 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Inputs always change 1 ns after a rising edge, so outputs are settled when read.
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_cnt(input string name, input int exp, input int got);
        checks++;
        if (got != exp) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Reset held four cycles, then time for the release flops.
    task automatic do_reset();
        rstn = 1'b0;
        step(4);
        chk("card_present", 1'b1, card_present);
        rstn = 1'b1;
        step(4);
    endtask
    // Software-driven power-up: supply, then clock, then reset release.
    task automatic power_up();
        regulator_bus_enable = 1'b1;
        card_power_on = 1'b1;
        step(2);
        card_clk_run = 1'b1;
        step(2);
        card_rst_release = 1'b1;
        step(2);
    endtask
    // Waits for the sequence, then follows it one step per cycle.
    task automatic pd_walk();
        int i;
        for (i = 0; i < 20 && pd_busy !== 1'b1; i++) step(1);
        chk("pd_busy", 1'b1, pd_busy);
        chk("card_rst_out", 1'b0, card_rst_out);
        step(1);
        chk("card_clk_out", 1'b0, card_clk_out);
        chk("card_io_oe", 1'b0, card_io_oe);
        step(1);
        chk("card_io_oe", 1'b1, card_io_oe);
        chk("card_supply_enable_out", 1'b1, card_supply_enable_out);
        step(1);
        chk("card_supply_enable_out", 1'b0, card_supply_enable_out);
        chk("vcc_on", 1'b0, vcc_on);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {supply_level_select, card_power_on, card_rst_release, card_clk_run} = 4'h0;
        {auto_pd_enable, force_pd, presence_irq_mask, presence_irq_clear} = 4'h0;
        {regulator_bus_enable, error_cnt, checks} = '0;
        card_seated = 1'b1;
        do_reset();
        power_up();
        chk("card_rst_out", 1'b1, card_rst_out);
        chk("card_supply_enable_out", 1'b1, card_supply_enable_out);
        chk("vcc_on", 1'b1, vcc_on);
        regulator_bus_enable = 1'b0;
        step(1);
        chk("vcc_on", 1'b0, vcc_on);
        regulator_bus_enable = 1'b1;
        // Both supply levels, then card clock rate running and stopped.
        for (int l = 0; l < 2; l++) begin
            supply_level_select = l[0];
            step(2);
            chk("card_level_out", l[0], card_level_out);
            chk("vcc_3v0", l[0] == LEVEL_3V0, vcc_3v0);
        end
        for (int r = 1; r >= 0; r--) begin
            card_clk_run = r[0];
            step(8);
            rises = 0;
            prev_clk = card_clk_out;
            repeat (64) begin
                step(1);
                rises += (card_clk_out === 1'b1 && prev_clk === 1'b0) ? 1 : 0;
                prev_clk = card_clk_out;
            end
            chk_cnt("card clock rises", r * 64 / ((CARD_CLK_DIV_LAST + 1) * 2), rises);
        end
        card_clk_run = 1'b1;
        // Removal with auto power-down off, then masked insertion.
        card_seated = 1'b0;
        step(6);
        chk("remove_flag", 1'b1, remove_flag);
        chk("presence_irq", 1'b1, presence_irq);
        chk("card_supply_enable_out", 1'b1, card_supply_enable_out);
        presence_irq_clear = 1'b1;
        step(1);
        presence_irq_clear = 1'b0;
        step(2);
        chk("remove_flag", 1'b0, remove_flag);
        presence_irq_mask = 1'b1;
        card_seated = 1'b1;
        step(6);
        chk("insert_flag", 1'b1, insert_flag);
        chk("presence_irq", 1'b0, presence_irq);
        presence_irq_mask = 1'b0;
        step(3);
        chk("presence_irq", 1'b1, presence_irq);
        // Forced power-down with auto off; software lines then ignored.
        force_pd = 1'b1;
        pd_walk();
        force_pd = 1'b0;
        card_power_on = 1'b0;
        step(2);
        card_power_on = 1'b1;
        step(3);
        chk("card_supply_enable_out", 1'b0, card_supply_enable_out);
        chk("card_io_sample", 1'b0, card_io_sample);
        // Reset in mid-run, then automatic power-down on removal.
        do_reset();
        power_up();
        auto_pd_enable = 1'b1;
        card_seated = 1'b0;
        pd_walk();
        end_of_test();
    end
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        $display("Error watchdog expected done seen timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
